// ### cpu_seq_pkg.sv
/*
 Shared constants and types for the program sequencer and interrupt core.
 Assumes a decoder on the same clock that presents one instruction at a time.
*/
package cpu_seq_pkg;
   localparam int PC_W     = 12;       // Program counter width (32 pages)
   localparam int OFS_W    = 7;        // Offset within a page
   localparam int SRC_N    = 7;        // Interrupt sources
   localparam int MC_DIV   = 3;        // System clocks per machine cycle
   localparam logic [2:0] SP_RESET = 3'h7;   // Depth pointer at reset
   localparam logic [PC_W-1:0] PAGE1_BASE = 12'h080; // Vector region
   localparam logic [PC_W-1:0] PAGE2_BASE = 12'h100; // Call page
   localparam logic [1:0] MC_LAST  = 2'h2;   // Last divider count

   // Operations the decoder hands over
   typedef enum logic [4:0] {
      OP_NOP, OP_SET_CY, OP_CLR_CY, OP_LOAD_A, OP_LOAD_B, OP_AB_TO_PAIR,
      OP_PAIR_TO_AB, OP_LOAD_D, OP_LOAD_DP, OP_BRANCH, OP_LONG_BR,
      OP_CALL, OP_CALL_LONG, OP_PAGE2_CALL, OP_RET, OP_TABLE,
      OP_DEPTH_TO_A, OP_SKIP_TEST, OP_REQ_TEST, OP_SET_EN, OP_EI, OP_DI,
      OP_RETI, OP_RAM_BIT
   } op_e;

   // Sequencer states, Gray along the table-fetch path
   typedef enum logic [0:0] {ST_RUN = 1'b0, ST_TABLE = 1'b1} seq_e;

   typedef struct packed {
      logic       z;        // file_group_sel
      logic [2:0] x;        // file_sel
      logic [3:0] y;        // digit_sel
   } ram_ptr_s;

   typedef struct packed {
      op_e             op;
      logic [1:0]      len;     // Instruction length in words
      logic [PC_W-1:0] target;  // Absolute target for branch and call
      logic [7:0]      imm;     // Immediate field
   } instr_s;

   typedef struct packed {
      ram_ptr_s   dp;
      logic       cy;
      logic       skip;
      logic [3:0] a;
      logic [3:0] b;
   } ctx_s;
endpackage : cpu_seq_pkg

// ### cpu_sequencer.sv
/*
 Program sequencer and interrupt core of a 4-bit CPU: registers, return
 stack, context save, paged program counter and vectored interrupts.
 Assumes the decoder raises i_exec on the last machine cycle of each
 instruction and that request events are one-cycle pulses on i_clk.
*/
`timescale 1ns/1ps
module cpu_sequencer
   import cpu_seq_pkg::*;
#(
   parameter int PAGES = 32                  // 16 or 32 pages
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_exec,      // Instruction completes
   input  wire instr_s           i_instr,     // Instruction fields
   input  wire logic             i_cond,      // Skip test result
   input  wire logic [9:0]       i_rom_data,  // Program word
   input  wire logic             i_wake,      // Return from back-up
   input  wire logic [SRC_N-1:0] i_req_event, // Request sources
   output logic                  o_mc_en,     // Machine cycle enable
   output logic [PC_W-1:0]       o_pc,        // Fetch address
   output logic                  o_skip,      // Skip current instruction
   output logic                  o_irq_take,  // Instruction discarded
   output logic [3:0]            o_a,         // prime_nibble_reg
   output logic [3:0]            o_b,         // helper_word
   output logic                  o_cy,        // carry_flag
   output logic [7:0]            o_ram_addr,  // ram_pointer
   output logic [3:0]            o_port_bit,  // Port bit from digit
   output logic [3:0]            o_bit_mask,  // RAM bit one-hot
   output logic [7:0]            o_pair,      // pair_word
   output logic [2:0]            o_depth,     // stack_depth
   output logic                  o_gate,      // global_irq_gate
   output logic [SRC_N-1:0]      o_req,       // Request flags
   output logic [SRC_N-1:0]      o_en         // Enable bits
);
   logic [1:0]      mc_cnt;        // Divider for the machine cycle
   seq_e            state;         // Sequencer state
   logic [PC_W-1:0] pc;            // Program counter
   logic [PC_W-1:0] stack [8];     // return_stack
   logic [2:0]      sp;            // stack_depth
   logic [3:0]      a, b;          // Working nibbles
   logic [7:0]      pair;          // pair_word
   logic [2:0]      d;             // page_pointer
   logic            cy, skip;      // Carry and skip flags
   ram_ptr_s        dp;            // ram_pointer
   ctx_s            ctx;           // irq_context_save
   logic            gate, gate_arm;// Gate and pending unmask
   logic [SRC_N-1:0] req, en;      // Flags and enables
   logic [1:0]      cond_pipe;     // Interrupt latency stages
   logic            run, take, push, pop;
   logic [SRC_N-1:0] ready;
   logic [2:0]      src;
   logic [PC_W-1:0] in_page, pc_inc, next_pc;

   assign o_mc_en = (mc_cnt == MC_LAST);

   // Machine cycle divider; slower logic runs on this enable
   always_ff @(posedge i_clk) begin
      if (i_rst || o_mc_en) begin
         mc_cnt <= 2'h0;
      end else begin
         mc_cnt <= mc_cnt + 2'h1;
      end
   end

   assign ready = req & en & {SRC_N{gate}};

   always_comb begin
      src = 3'h0;
      for (int i = SRC_N - 1; i >= 0; i--) begin
         if (ready[i]) begin
            src = i[2:0];
         end
      end
   end

   // Instruction boundary in the running state
   assign run  = o_mc_en && i_exec && (state == ST_RUN);
   assign take = run && (|ready) && cond_pipe[1];
   assign o_irq_take = take;

   // in-page address from pointer and prime nibble
   assign in_page = {i_instr.imm[4:0], d, a};

   // carry from offset runs into page field
   always_comb begin
      pc_inc = pc + PC_W'(i_instr.len);
      // sixteen pages wrap at the half
      if (PAGES == 16) begin
         pc_inc[PC_W-1] = 1'b0;
      end
   end

   // Push and pop of the shared stack
   always_comb begin
      push = 1'b0;
      pop  = 1'b0;
      if (take) begin
         push = 1'b1;
      end else if (run && !skip) begin
         unique case (i_instr.op)
            OP_CALL, OP_CALL_LONG, OP_PAGE2_CALL, OP_TABLE: push = 1'b1;
            OP_RET, OP_RETI: pop = 1'b1;
            default: ;
         endcase
      end else if (o_mc_en && state == ST_TABLE) begin
         pop = 1'b1;
      end
   end

   // Next program counter
   always_comb begin
      next_pc = pc;
      if (take) begin
         // vector at two words per source
         next_pc = PAGE1_BASE + PC_W'({src, 1'b0});
      end else if (o_mc_en && state == ST_TABLE) begin
         next_pc = stack[sp];
      end else if (run) begin
         next_pc = pc_inc;
         if (!skip) begin
            unique case (i_instr.op)
               OP_BRANCH, OP_CALL: next_pc = i_instr.target;
               OP_LONG_BR, OP_CALL_LONG, OP_TABLE: next_pc = in_page;
               OP_PAGE2_CALL:
                  next_pc = PAGE2_BASE | PC_W'(i_instr.imm[OFS_W-1:0]);
               OP_RET, OP_RETI: next_pc = stack[sp];
               default: ;
            endcase
         end
      end
   end

   // Program counter and table-fetch sequencing
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pc    <= '0;
         state <= ST_RUN;
      end else begin
         pc <= next_pc;
         if (run && !take && !skip && i_instr.op == OP_TABLE) begin
            state <= ST_TABLE;
         end else if (o_mc_en) begin
            state <= ST_RUN;
         end
      end
   end

   // Return stack and depth pointer
   always_ff @(posedge i_clk) begin
      if (i_rst || i_wake) begin
         sp <= SP_RESET;
      end else if (push) begin
         // wraps and overwrites the oldest entry
         sp            <= sp + 3'h1;
         stack[sp + 3'h1] <= take ? pc : pc_inc;
      end else if (pop) begin
         sp <= sp - 3'h1;
      end
   end

   // Working registers, carry and pointers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         a    <= 4'h0;
         b    <= 4'h0;
         pair <= 8'h00;
         d    <= 3'h0;
         cy   <= 1'b0;
         dp   <= '0;
      end else if (take) begin
         // Context already captured; registers keep their values
      end else if (o_mc_en && state == ST_TABLE) begin
         // low eight bits of the word into B and A
         {b, a} <= i_rom_data[7:0];
      end else if (run && ctx_restore_ok()) begin
         dp <= ctx.dp;
         cy <= ctx.cy;
         a  <= ctx.a;
         b  <= ctx.b;
      end else if (run && !skip) begin
         unique case (i_instr.op)
            OP_SET_CY:     cy <= 1'b1;
            OP_CLR_CY:     cy <= 1'b0;
            OP_LOAD_A:     a <= i_instr.imm[3:0];
            OP_LOAD_B:     b <= i_instr.imm[3:0];
            OP_AB_TO_PAIR: pair <= {b, a};
            OP_PAIR_TO_AB: {b, a} <= pair;
            OP_LOAD_D:     d <= i_instr.imm[2:0];
            OP_LOAD_DP:    dp <= i_instr.imm;
            OP_DEPTH_TO_A: a <= {1'b0, sp};
            default: ;
         endcase
      end
   end

   function automatic logic ctx_restore_ok();
      return !skip && i_instr.op == OP_RETI;
   endfunction : ctx_restore_ok

   // Skip flag: set by a true test, used by the next instruction
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         skip <= 1'b0;
      end else if (take) begin
         // pending skip moves into the save
         skip <= 1'b0;
      end else if (run && ctx_restore_ok()) begin
         skip <= ctx.skip;
      end else if (run) begin
         if (skip) begin
            skip <= 1'b0;
         end else begin
            unique case (i_instr.op)
               OP_SKIP_TEST, OP_RAM_BIT: skip <= i_cond;
               // skip test valid only while disabled
               OP_REQ_TEST:
                  skip <= req[i_instr.imm[2:0]] && !en[i_instr.imm[2:0]];
               default: skip <= 1'b0;
            endcase
         end
      end
   end

   // single-stage context save on entry only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctx <= '0;
      end else if (take) begin
         ctx <= '{dp: dp, cy: cy, skip: skip, a: a, b: b};
      end
   end

   // Global gate with one-instruction unmask delay
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         gate     <= 1'b0;
         gate_arm <= 1'b0;
      end else if (take) begin
         // cleared when an interrupt is taken
         gate     <= 1'b0;
         gate_arm <= 1'b0;
      end else if (run && !skip && i_instr.op == OP_DI) begin
         gate     <= 1'b0;
         gate_arm <= 1'b0;
      end else if (run) begin
         gate     <= gate | gate_arm;
         gate_arm <= !skip && i_instr.op == OP_EI;
      end
   end

   // Enable bits written by the decoder
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         en <= '0;
      end else if (run && !take && !skip && i_instr.op == OP_SET_EN) begin
         en <= i_instr.imm[SRC_N-1:0];
      end
   end

   // Request flags: a new event wins over any clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         req <= '0;
      end else begin
         for (int i = 0; i < SRC_N; i++) begin
            if (i_req_event[i]) begin
               req[i] <= 1'b1;
            end else if (take && src == i[2:0]) begin
               req[i] <= 1'b0;
            end else if (run && !skip && i_instr.op == OP_REQ_TEST
                         && i_instr.imm[2:0] == i[2:0] && !en[i]) begin
               req[i] <= 1'b0;
            end
         end
      end
   end

   // Latency pipeline on machine cycles
   always_ff @(posedge i_clk) begin
      if (i_rst || take) begin
         cond_pipe <= 2'b00;
      end else if (o_mc_en) begin
         cond_pipe <= {cond_pipe[0] & (|ready), |ready};
      end
   end

   assign o_pc       = pc;
   assign o_skip     = skip;
   assign o_a        = a;
   assign o_b        = b;
   assign o_cy       = cy;
   assign o_ram_addr = dp;
   assign o_port_bit = dp.y;
   // one-hot bit within a 4-bit word
   assign o_bit_mask = 4'h1 << i_instr.imm[1:0];
   assign o_pair     = pair;
   assign o_depth    = sp;
   assign o_gate     = gate;
   assign o_req      = req;
   assign o_en       = en;

   a_carry_set: assert property (@(posedge i_clk) disable iff (i_rst)
      run && !skip && !take && i_instr.op == OP_SET_CY |=> cy)
      else $error("carry not set");
   a_depth_reset: assert property (@(posedge i_clk)
      i_rst |=> sp == SP_RESET) else $error("depth not seven");
   a_push_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
      push && !i_wake |=> sp == $past(sp) + 3'h1)
      else $error("push did not advance");
   a_take_needs: assert property (@(posedge i_clk) disable iff (i_rst)
      take |-> gate && (req[src] && en[src])) else $error("bad take");
   a_gate_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      take |=> !gate ##1 !gate) else $error("gate stayed open");
   a_vector_load: assert property (@(posedge i_clk) disable iff (i_rst)
      take |=> pc == PAGE1_BASE + PC_W'({$past(src), 1'b0}))
      else $error("wrong vector");
   a_ctx_saved: assert property (@(posedge i_clk) disable iff (i_rst)
      take |=> ctx.a == $past(a) && ctx.skip == $past(skip) && !skip)
      else $error("context not saved");
   a_unmask_late: assert property (@(posedge i_clk) disable iff (i_rst)
      run && !skip && !take && !gate && i_instr.op == OP_EI |=> !gate)
      else $error("gate opened early");
   a_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      take && !i_req_event[src] |=> !req[$past(src)])
      else $error("flag not cleared");

   c_irq_taken: cover property (@(posedge i_clk) disable iff (i_rst) take);
   c_table_done: cover property (@(posedge i_clk) disable iff (i_rst)
      state == ST_TABLE ##1 state == ST_RUN);
   c_stack_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
      push && sp == 3'h7);
endmodule : cpu_sequencer

// ### rom_model.sv
/*
 Program memory seen by the sequencer: a fixed pattern of 10-bit words.
 Assumes the sequencer reads it combinationally from its fetch address.
*/
`timescale 1ns/1ps
module rom_model
   import cpu_seq_pkg::*;
(
   input  wire logic [PC_W-1:0] i_addr,   // Fetch address
   output logic      [9:0]      o_word    // Program word
);
   // ten-bit program words
   // Upper bits are the inverted low address bits, zero only where both are set, so a table fetch that leaks them shows up
   always_comb begin
      o_word = {~i_addr[1:0], i_addr[7:0] + 8'h13};
   end
endmodule : rom_model

// ### cpu_sequencer_and_interrupt_unit_tb.sv
/*
 Self-checking bench for the sequencer: table of plain cases, then calls,
 page wrap, table fetch and an interrupt round trip.
 Assumes the package op encodings and the hand-over timing of the core.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module cpu_sequencer_and_interrupt_unit_tb;
   import cpu_seq_pkg::*;
   typedef struct packed {
      op_e        op;
      logic [7:0] imm;
      logic [3:0] sel;    // Which output to look at
      logic [7:0] exp;
   } row_s;
   logic i_clk = 1'b0, i_rst = 1'b1, i_exec = 1'b0, i_wake = 1'b0;
   instr_s i_instr = '0;
   logic [SRC_N-1:0] i_req_event = '0;
   logic [9:0] rom;
   logic mc, tk, sk, gate;
   logic [PC_W-1:0] pc;
   logic [3:0] a, b, pbit;
   logic cy;
   logic cond = 1'b0;       // Skip test result fed to the core
   logic [3:0] bmask;       // One-hot RAM bit from the core
   logic [7:0] ram, pair;
   logic [2:0] dep;
   logic [SRC_N-1:0] req, en;
   int error_cnt = 0, total_checks = 0, cycles = 0, n;
   row_s rows [15];

   // System clock, 4 ns
   always #2 i_clk = ~i_clk;

   cpu_sequencer uut (.i_clk(i_clk), .i_rst(i_rst), .i_exec(i_exec),
      .i_instr(i_instr), .i_cond(cond), .i_rom_data(rom), .i_wake(i_wake),
      .i_req_event(i_req_event), .o_mc_en(mc), .o_pc(pc), .o_skip(sk),
      .o_irq_take(tk), .o_a(a), .o_b(b), .o_cy(cy), .o_ram_addr(ram),
      .o_port_bit(pbit), .o_bit_mask(bmask), .o_pair(pair), .o_depth(dep),
      .o_gate(gate), .o_req(req), .o_en(en));
   rom_model rom_i (.i_addr(pc), .o_word(rom));

   // Verdict and end of run
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // A hang is cut short well beyond the few hundred cycles needed
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         complete_run();
      end
   end

   // One instruction: held until a machine-cycle edge takes it
   task automatic op(input op_e o, input logic [PC_W-1:0] t = '0,
                     input logic [7:0] im = '0, input logic [1:0] ln = 2'h1);
      @(posedge i_clk);
      i_instr <= '{op: o, len: ln, target: t, imm: im};
      i_exec  <= 1'b1;
      do @(posedge i_clk); while (mc !== 1'b1);
      n = (tk === 1'b1) ? -1 : n;
      i_exec  <= 1'b0;
      #1;
   endtask : op

   // One idle machine cycle, needed after a table fetch
   task automatic gap;
      do @(posedge i_clk); while (mc !== 1'b1);
      #1;
   endtask : gap

   function automatic logic [7:0] pick(input logic [3:0] s);
      case (s)
         4'h0: pick = {4'h0, a};
         4'h1: pick = {4'h0, b};
         4'h2: pick = {7'h00, cy};
         4'h3: pick = pair;
         4'h4: pick = {5'h00, dep};
         4'h5: pick = {7'h00, gate};
         4'h6: pick = {1'b0, en};
         4'h7: pick = ram;
         default: pick = {4'h0, pbit};
      endcase
   endfunction : pick

   initial begin
      rows = '{'{OP_SET_CY, 8'h00, 4'h2, 8'h01}, '{OP_CLR_CY, 8'h00, 4'h2, 8'h00},
         '{OP_LOAD_A, 8'h05, 4'h0, 8'h05}, '{OP_LOAD_B, 8'h0C, 4'h1, 8'h0C},
         '{OP_AB_TO_PAIR, 8'h00, 4'h3, 8'hC5}, '{OP_LOAD_A, 8'h03, 4'h0, 8'h03},
         '{OP_PAIR_TO_AB, 8'h00, 4'h0, 8'h05}, '{OP_DEPTH_TO_A, 8'h00, 4'h0, 8'h07},
         '{OP_LOAD_DP, 8'hA6, 4'h8, 8'h06}, '{OP_SET_EN, 8'h7F, 4'h6, 8'h7F},
         '{OP_EI, 8'h00, 4'h5, 8'h00}, '{OP_NOP, 8'h00, 4'h5, 8'h01},
         '{OP_DI, 8'h00, 4'h5, 8'h00}, '{OP_SET_EN, 8'h00, 4'h6, 8'h00},
         '{OP_NOP, 8'h00, 4'h7, 8'hA6}};
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      `CHK({gate, en, req, pc}, {15'h0000, 12'h000})
      `CHK(dep, SP_RESET)
      $display("test reset done");
      foreach (rows[i]) begin
         op(rows[i].op, '0, rows[i].imm);
         `CHK(pick(rows[i].sel), rows[i].exp)
      end
      $display("test table rows done");
      // Calls wrap the depth pointer after eight pushes
      op(OP_BRANCH, 12'h040);
      for (int i = 0; i < 9; i++) begin
         op(OP_CALL, 12'h200 + 12'(i));
         `CHK(dep, i[2:0])
      end
      op(OP_RET);
      `CHK({dep, pc}, {3'h7, 12'h208})
      op(OP_RET);
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
      #1;
      `CHK(dep, 3'h7)
      $display("test stack done");
      // Page wrap, two-word length and page-two call
      op(OP_BRANCH, 12'h07F);
      op(OP_NOP);
      `CHK(pc, 12'h080)
      op(OP_BRANCH, 12'h0FE);
      op(OP_NOP, '0, '0, 2'h2);
      `CHK(pc, 12'h100)
      op(OP_PAGE2_CALL, '0, 8'h05);
      `CHK({dep, pc}, {3'h0, 12'h105})
      op(OP_RET);
      $display("test pc done");
      // Table fetch through page 5, offset {d, a}
      op(OP_BRANCH, 12'h050);
      op(OP_LOAD_D, '0, 8'h03);
      op(OP_LOAD_A, '0, 8'h04);
      op(OP_TABLE, '0, 8'h05);
      `CHK(pc, 12'h2B4)
      gap();
      `CHK({b, a, pc, dep}, {8'hC7, 12'h053, 3'h7})
      $display("test table fetch done");
      // Interrupt round trip with two sources pending
      op(OP_SET_EN, '0, 8'h06);
      op(OP_EI);
      op(OP_NOP);
      op(OP_BRANCH, 12'h300);
      op(OP_SET_CY);
      op(OP_LOAD_A, '0, 8'h09);
      op(OP_LOAD_B, '0, 8'h02);
      @(posedge i_clk);
      i_req_event <= 7'h06;
      @(posedge i_clk);
      i_req_event <= 7'h00;
      n = 0;
      while (n >= 0 && n < 6) begin
         op(OP_NOP);
         // Until the take, each plain instruction just steps the counter
         if (n >= 0) begin
            n++;
            `CHK(pc, 12'h303 + n[11:0])
         end
      end
      `CHK(n, -1)
      `CHK({uut.o_pc, gate, req, dep}, {12'h082, 1'b0, 7'h04, 3'h0})
      // Trash the context inside the service routine
      op(OP_CLR_CY);
      op(OP_LOAD_A);
      op(OP_LOAD_B);
      op(OP_LOAD_DP);
      op(OP_RETI);
      `CHK({a, b, cy, ram}, {8'h92, 1'b1, 8'hA6})
      `CHK({dep, pc}, {3'h7, 12'h304})
      $display("test interrupt done");
      // Enabled source is not cleared by its skip test
      op(OP_REQ_TEST, '0, 8'h02);
      `CHK({req, sk, gate}, {7'h04, 1'b0, 1'b0})
      op(OP_SET_EN);
      op(OP_REQ_TEST, '0, 8'h02);
      `CHK({req, sk}, {7'h00, 1'b1})
      // The pending skip turns this load into a plain step
      op(OP_LOAD_A, '0, 8'h0F);
      `CHK({sk, a}, {1'b0, 4'h9})
      // A true bit test sets the skip flag; mask follows the bit number
      @(posedge i_clk);
      cond <= 1'b1;
      op(OP_RAM_BIT, '0, 8'h02);
      `CHK({sk, bmask}, {1'b1, 4'h4})
      @(posedge i_clk);
      cond <= 1'b0;
      op(OP_NOP);
      $display("test skip done");
      // Long branch and long call take {page, d, a}
      op(OP_LONG_BR, '0, 8'h06);
      `CHK(pc, 12'h339)
      op(OP_CALL_LONG, '0, 8'h01);
      `CHK({dep, pc}, {3'h0, 12'h0B9})
      op(OP_RET);
      `CHK({dep, pc}, {3'h7, 12'h33A})
      $display("test long branch done");
      complete_run();
   end
endmodule : cpu_sequencer_and_interrupt_unit_tb
